// File: rtl/bsrp_pkg.sv
// bsrp_pkg: constants, line states and the state record of the reset, sleep and presence block.
// assumes a single 125 MHz clock; all times are converted to cycles here.
package bsrp_pkg;

  localparam int CLK_PERIOD_NS = 8;

  // least low time on the line that counts as a bus reset (reset_low_pulse_time)
  localparam int RSTL_MIN_NS   = 480000;
  // presence: wait after the line rises, then hold the line low
  localparam int PWAIT_NS      = 30000;
  localparam int PLOW_NS       = 120000;
  // length of the self-made reset state at power-up or after power-fail
  localparam int POR_NS        = 100000;
  // power-up presence must be over this long after power is applied
  localparam int PUP_LIMIT_NS  = 2000000;

  localparam int RSTL_CYC      = (RSTL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWAIT_CYC     = (PWAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLOW_CYC      = (PLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CYC       = (POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PUP_LIMIT_CYC = PUP_LIMIT_NS / CLK_PERIOD_NS;

  localparam int CNT_W         = 18;

  // synchronised pin positions
  localparam int NPIN          = 5;
  localparam int PIN_WAKE      = 0;
  localparam int PIN_SLEEP     = 1;
  localparam int PIN_RST       = 2;
  localparam int PIN_LINE      = 3;
  localparam int PIN_PFAIL     = 4;
  // idle pin levels: sleep, reset and line pulled high
  localparam logic [NPIN-1:0] PIN_IDLE = 5'h0e;

  // cycles the reset pin is not believed after the block stops driving it;
  // must outlast the synchroniser and filter, else our own release reads as an outside reset
  localparam logic [2:0] REL_BLANK = 3'h5;

  typedef enum logic [1:0] {
    LN_IDLE  = 2'b00,
    LN_PWAIT = 2'b01,
    LN_PLOW  = 2'b10
  } bsrp_line_t;

  typedef struct packed {
    bsrp_line_t       line;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] por_cnt;
    logic [CNT_W-1:0] up_cnt;
    logic [2:0]       rel_cnt;
    logic             drive_rst;
    logic             in_rst;
    logic             awake;
    logic             err_b;
    logic             line_oe;
    logic             bus_rst;
    logic             pup_done;
  } bsrp_state_t;

endpackage : bsrp_pkg

// File: rtl/bsrp_pins_if.sv
// bsrp_pins_if: raw pin levels in, filtered levels and edge pulses out.
// assumes the producer and the consumer share the block clock.
`timescale 1ns/1ps
interface bsrp_pins_if #(parameter int N = 5);
  logic [N-1:0] raw;
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport sync (input raw, output level, output rise, output fall);
  modport user (output raw, input level, input rise, input fall);
endinterface : bsrp_pins_if

// File: rtl/bsrp_sync.sv
// bsrp_sync: three-flop synchroniser per pin with agreement filter and edge pulses.
// assumes raw inputs are asynchronous to clock.
`timescale 1ns/1ps
module bsrp_sync
  import bsrp_pkg::*;
#(
  parameter int            N    = 5,
  parameter logic [N-1:0]  IDLE = '0
)(
  input wire logic clock,   // block clock
  input wire logic rst_b,   // async reset, active low
  bsrp_pins_if.sync pins    // raw in, clean level and edges out
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] level;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
  } bsrp_sync_t;

  bsrp_sync_t r;
  bsrp_sync_t next_r;

  always_comb
  begin
    next_r       = r;
    next_r.s1    = pins.raw;
    next_r.s2    = r.s1;
    next_r.s3    = r.s2;
    // a change is taken only once the second and third stage agree
    next_r.level = (r.s3 & ~(r.s2 ^ r.s3)) | (r.level & (r.s2 ^ r.s3));
    next_r.rise  = next_r.level & ~r.level;
    next_r.fall  = ~next_r.level & r.level;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      r <= '{s1: IDLE, s2: IDLE, s3: IDLE, level: IDLE, rise: '0, fall: '0};
    else
      r <= next_r;
  end

  assign pins.level = r.level;
  assign pins.rise  = r.rise;
  assign pins.fall  = r.fall;

endmodule : bsrp_sync

// File: rtl/bsrp_top.sv
// bsrp_top: reset pin, sleep and wake, error flag and presence pulse of the bridge.
// assumes error events arrive as one-cycle pulses on clock; all pins are asynchronous.
`timescale 1ns/1ps
// How it works
// - low on shared reset pin resets device
// - internal reset drives reset pin low throughout
// - wake rising edge leaves sleep mode
// - wake edges ignored while awake
// - sleep falling edge enters sleep mode
// - any detected error drives error output low
// - single-wire bus reset clears error output
// - presence low pulse follows bus reset
// - power-up presence finished within two milliseconds
// - awake output high awake, low asleep
module bsrp_top
  import bsrp_pkg::*;
#(
  parameter int RSTL_CYCLES  = RSTL_CYC,       // low cycles that make a bus reset
  parameter int PWAIT_CYCLES = PWAIT_CYC,      // wait before presence
  parameter int PLOW_CYCLES  = PLOW_CYC,       // presence low length
  parameter int POR_CYCLES   = POR_CYC,        // internal reset length
  parameter int PUP_CYCLES   = PUP_LIMIT_CYC   // power-up presence limit
)(
  input  wire logic clock,             // 125 MHz block clock
  input  wire logic rst_b,             // power-on reset, async, active low
  input  wire logic reset_pin_in,      // reset pin level
  output wire logic reset_pin_out,     // reset pin drive value
  output wire logic reset_pin_oe,      // reset pin output enable
  input  wire logic power_fail,        // supply monitor, high on failure
  input  wire logic wake_pin,          // wake input
  input  wire logic sleep_pin,         // sleep input
  input  wire logic line_in,           // single-wire line level
  output wire logic line_out,          // single-wire line drive value
  output wire logic line_oe,           // single-wire line output enable
  input  wire logic err_invalid_cmd,   // pulse: invalid command
  input  wire logic err_crc,           // pulse: packet crc16 mismatch
  input  wire logic err_nack,          // pulse: peripheral did not acknowledge
  output wire logic error_flag_out_b,  // error output, low on error
  output wire logic awake,             // high awake, low asleep
  output wire logic bus_reset_pulse,   // pulse: bus reset seen
  output wire logic in_reset           // high while device is in reset
);

  localparam logic [CNT_W-1:0] RSTL_C  = CNT_W'(RSTL_CYCLES);
  localparam logic [CNT_W-1:0] PWAIT_C = CNT_W'(PWAIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] PLOW_C  = CNT_W'(PLOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] POR_C   = CNT_W'(POR_CYCLES);
  localparam logic [CNT_W-1:0] PUP_C   = CNT_W'(PUP_CYCLES);

  bsrp_pins_if #(.N(NPIN)) pins ();

  assign pins.raw[PIN_WAKE]  = wake_pin;
  assign pins.raw[PIN_SLEEP] = sleep_pin;
  assign pins.raw[PIN_RST]   = reset_pin_in;
  assign pins.raw[PIN_LINE]  = line_in;
  assign pins.raw[PIN_PFAIL] = power_fail;

  bsrp_sync #(.N(NPIN), .IDLE(PIN_IDLE)) u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .pins  (pins)
  );

  bsrp_state_t r;
  bsrp_state_t next_r;

  logic pfail;
  logic ext_rst;
  logic int_rst;
  logic dev_rst;
  logic err_any;
  logic det_bus_rst;
  logic wake_rise;
  logic sleep_fall;

  assign pfail      = pins.level[PIN_PFAIL];
  assign wake_rise  = pins.rise[PIN_WAKE];
  assign sleep_fall = pins.fall[PIN_SLEEP];
  assign err_any    = err_invalid_cmd | err_crc | err_nack;
  // our own drive reads back low through the synchroniser, so it is blanked
  assign ext_rst    = !pins.level[PIN_RST] && !r.drive_rst && (r.rel_cnt == 3'h0);
  assign int_rst    = (r.por_cnt != '0) || pfail;
  assign dev_rst    = int_rst || ext_rst;

  always_comb
  begin
    next_r         = r;
    next_r.bus_rst = 1'b0;
    det_bus_rst    = 1'b0;
    if (r.por_cnt != '0)
      next_r.por_cnt = r.por_cnt - 1'b1;
    if (pfail)
      next_r.por_cnt = POR_C;
    if (r.up_cnt != '1 && !r.pup_done)
      next_r.up_cnt = r.up_cnt + 1'b1;
    if (dev_rst)
    begin
      // reset state: awake, error cleared, presence armed for after release
      next_r.awake = 1'b1;
      next_r.err_b = 1'b1;
      next_r.line  = LN_PWAIT;
      next_r.cnt   = '0;
    end
    else
    begin
      if (r.awake && sleep_fall)
        next_r.awake = 1'b0;
      else if (!r.awake && wake_rise)
        next_r.awake = 1'b1;
      case (r.line)
        LN_IDLE:
        begin
          if (!pins.level[PIN_LINE])
          begin
            if (r.cnt != '1)
              next_r.cnt = r.cnt + 1'b1;
          end
          else
          begin
            next_r.cnt = '0;
            if (r.cnt >= RSTL_C)
            begin
              det_bus_rst    = 1'b1;
              next_r.bus_rst = 1'b1;
              next_r.line    = LN_PWAIT;
            end
          end
        end
        LN_PWAIT:
        begin
          next_r.cnt = r.cnt + 1'b1;
          if (r.cnt >= PWAIT_C)
          begin
            next_r.cnt  = '0;
            next_r.line = LN_PLOW;
          end
        end
        LN_PLOW:
        begin
          next_r.cnt = r.cnt + 1'b1;
          if (r.cnt >= PLOW_C)
          begin
            next_r.cnt      = '0;
            next_r.line     = LN_IDLE;
            next_r.pup_done = 1'b1;
          end
        end
        default:
        begin
          next_r.cnt  = '0;
          next_r.line = LN_IDLE;
        end
      endcase
      if (det_bus_rst)
        next_r.err_b = 1'b1;
    end
    // a new error beats a clear in the same cycle
    if (err_any)
      next_r.err_b = 1'b0;
    next_r.line_oe   = (next_r.line == LN_PLOW) && !dev_rst;
    next_r.drive_rst = (next_r.por_cnt != '0) || pfail;
    next_r.rel_cnt   = next_r.drive_rst ? REL_BLANK :
                       ((r.rel_cnt != 3'h0) ? r.rel_cnt - 1'b1 : 3'h0);
    next_r.in_rst    = dev_rst;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      r <= '{line: LN_PWAIT, cnt: '0, por_cnt: POR_C, up_cnt: '0, rel_cnt: REL_BLANK,
             drive_rst: 1'b1, in_rst: 1'b1, awake: 1'b1, err_b: 1'b1, line_oe: 1'b0,
             bus_rst: 1'b0, pup_done: 1'b0};
    else
      r <= next_r;
  end

  assign reset_pin_out    = 1'b0;
  assign reset_pin_oe     = r.drive_rst;
  assign line_out         = 1'b0;
  assign line_oe          = r.line_oe;
  assign error_flag_out_b = r.err_b;
  assign awake            = r.awake;
  assign bus_reset_pulse  = r.bus_rst;
  assign in_reset         = r.in_rst;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_ext_rst;
    (ext_rst && !err_any) |=> in_reset && awake && error_flag_out_b;
  endproperty
  a_ext_rst: assert property (p_ext_rst) else $error("external reset not taken");

  property p_int_drive;
    (pfail || r.por_cnt != '0) |=> (reset_pin_oe || r.por_cnt == '0) && !reset_pin_out;
  endproperty
  a_int_drive: assert property (p_int_drive) else $error("reset pin not driven in reset");

  property p_wake;
    (!r.awake && wake_rise && !dev_rst) |=> awake;
  endproperty
  a_wake: assert property (p_wake) else $error("wake edge did not wake");

  property p_wake_ign;
    (r.awake && wake_rise && !sleep_fall && !dev_rst) |=> awake;
  endproperty
  a_wake_ign: assert property (p_wake_ign) else $error("wake edge changed awake state");

  property p_sleep;
    (r.awake && sleep_fall && !dev_rst) |=> !awake;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep edge did not sleep");

  property p_err_set;
    err_any |=> !error_flag_out_b;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error not flagged");

  property p_err_clr;
    (det_bus_rst && !err_any) |=> error_flag_out_b && bus_reset_pulse;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("bus reset did not clear error");

  property p_presence;
    bus_reset_pulse |-> r.line == LN_PWAIT && !line_oe && r.cnt == '0;
  endproperty
  a_presence: assert property (p_presence) else $error("presence not armed by bus reset");

  property p_pres_len;
    $rose(line_oe) |-> $past(r.line) == LN_PWAIT && $past(r.cnt) >= PWAIT_C;
  endproperty
  a_pres_len: assert property (p_pres_len) else $error("presence started early");

  property p_pup;
    $rose(r.pup_done) |-> r.up_cnt <= PUP_C;
  endproperty
  a_pup: assert property (p_pup) else $error("power-up presence too late");

  property p_awake_pin;
    $fell(awake) |-> $past(sleep_fall) && !$past(dev_rst);
  endproperty
  a_awake_pin: assert property (p_awake_pin) else $error("awake fell without sleep edge");

  property p_err_hold;
    (!error_flag_out_b && !det_bus_rst && !dev_rst) |=> !error_flag_out_b;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag released early");

  property p_stay_asleep;
    (!r.awake && !wake_rise && !dev_rst) |=> !awake;
  endproperty
  a_stay_asleep: assert property (p_stay_asleep) else $error("left sleep without wake");

  c_bus_rst: cover property (bus_reset_pulse ##[1:1000] !bus_reset_pulse);
  c_sleep_wake: cover property ($fell(awake) ##[1:100] $rose(awake));
  c_pup: cover property ($rose(r.pup_done));
  c_ext_rst: cover property (ext_rst);

endmodule : bsrp_top

// File: test/bsrp_ctrl_model.sv
// bsrp_ctrl_model: single-wire bus controller plus an outside reset source.
// assumes both wires have pull-ups and share the block clock.
`timescale 1ns/1ps
module bsrp_ctrl_model (
  input  wire logic clock,          // block clock
  input  wire logic line_oe,        // device drives line
  input  wire logic line_out,       // device line value
  input  wire logic reset_pin_oe,   // device drives reset pin
  input  wire logic reset_pin_out,  // device reset pin value
  output wire logic line_in,        // resolved line level
  output wire logic reset_pin_in    // resolved reset pin level
);
  logic ctl_low = 1'b0;
  logic ext_low = 1'b0;

  // wired lines: a released line floats back to its pull-up
  assign line_in      = !((line_oe && !line_out) || ctl_low);
  assign reset_pin_in = !((reset_pin_oe && !reset_pin_out) || ext_low);

  // low pulse, then watch for a presence low while the line is released
  task automatic bus_reset(input int low_cyc, output logic seen);
    seen = 1'b0;
    @(posedge clock);
    ctl_low <= 1'b1;
    repeat (low_cyc) @(posedge clock);
    ctl_low <= 1'b0;
    repeat (60)
    begin
      @(posedge clock);
      #1;
      if (line_in === 1'b0)
        seen = 1'b1;
    end
  endtask : bus_reset

  task automatic pull_reset(input int n);
    @(posedge clock);
    ext_low <= 1'b1;
    repeat (n) @(posedge clock);
    ext_low <= 1'b0;
  endtask : pull_reset
endmodule : bsrp_ctrl_model

// File: test/tb.sv
// tb: self-checking bench for bsrp_top with shortened counts.
// assumes bsrp_ctrl_model resolves the line and reset pin wires.
`timescale 1ns/1ps
module tb;
  import bsrp_pkg::*;
  localparam int POR = 16;
  localparam int PUP = 200;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic power_fail = 1'b0;
  logic wake_pin = 1'b0;
  logic sleep_pin = 1'b1;
  logic [2:0] err = 3'h0;
  wire logic reset_pin_in, reset_pin_out, reset_pin_oe, line_in, line_out, line_oe;
  wire logic error_flag_out_b, awake, bus_reset_pulse, in_reset;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #4 clock = ~clock;

  bsrp_top #(.RSTL_CYCLES(20), .PWAIT_CYCLES(5), .PLOW_CYCLES(10), .POR_CYCLES(POR), .PUP_CYCLES(PUP)) u_dut (
    .clock(clock), .rst_b(rst_b), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe), .power_fail(power_fail), .wake_pin(wake_pin), .sleep_pin(sleep_pin),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .err_invalid_cmd(err[0]), .err_crc(err[1]),
    .err_nack(err[2]), .error_flag_out_b(error_flag_out_b), .awake(awake),
    .bus_reset_pulse(bus_reset_pulse), .in_reset(in_reset));

  bsrp_ctrl_model u_model (
    .clock(clock), .line_oe(line_oe), .line_out(line_out), .reset_pin_oe(reset_pin_oe),
    .reset_pin_out(reset_pin_out), .line_in(line_in), .reset_pin_in(reset_pin_in));

  task automatic check(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  // pin edges take a few sync cycles, so wait bounded for the level
  task automatic wait_awake(input logic exp);
    for (int i = 0; i < 10 && awake !== exp; i++)
      step(1);
  endtask : wait_awake

  task automatic t_powerup;
    int n;
    logic rose;
    n = 0;
    rose = 1'b0;
    check(reset_pin_oe, 1'b1, "reset pin not driven");
    while (n < PUP && !(rose && !line_oe))
    begin
      step(1);
      n++;
      rose = rose | line_oe;
      if (n == POR / 2)
        check(reset_pin_oe, 1'b1, "reset pin released early");
    end
    check(rose && n < PUP, 1'b1, "power-up presence late");
    check(reset_pin_oe, 1'b0, "reset pin still driven");
    check(awake, 1'b1, "not awake after reset");
    check(error_flag_out_b, 1'b1, "error set after reset");
    $display("powerup test done");
  endtask : t_powerup

  task automatic t_sleep_wake;
    @(posedge clock) wake_pin <= 1'b1;
    step(8);
    check(awake, 1'b1, "wake edge while awake");
    @(posedge clock) wake_pin <= 1'b0;
    @(posedge clock) sleep_pin <= 1'b0;
    wait_awake(1'b0);
    check(awake, 1'b0, "sleep edge missed");
    @(posedge clock) sleep_pin <= 1'b1;
    step(6);
    @(posedge clock) sleep_pin <= 1'b0;
    step(8);
    check(awake, 1'b0, "left sleep on sleep edge");
    @(posedge clock) sleep_pin <= 1'b1;
    step(6);
    @(posedge clock) wake_pin <= 1'b1;
    wait_awake(1'b1);
    check(awake, 1'b1, "wake edge missed");
    @(posedge clock) wake_pin <= 1'b0;
    step(6);
    $display("sleep and wake test done");
  endtask : t_sleep_wake

  task automatic t_errors;
    logic seen;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clock) err <= 3'h1 << k;
      @(posedge clock) err <= 3'h0;
      #1;
      check(error_flag_out_b, 1'b0, "error not flagged");
      u_model.bus_reset(10, seen);
      check(error_flag_out_b, 1'b0, "error cleared by short pulse");
      check(seen, 1'b0, "presence after short pulse");
      fork
        u_model.bus_reset(30, seen);
        begin
          for (int i = 0; i < 80 && bus_reset_pulse !== 1'b1; i++)
            step(1);
          check(bus_reset_pulse, 1'b1, "bus reset not seen");
          check(error_flag_out_b, 1'b1, "error not cleared");
        end
      join
      check(seen, 1'b1, "no presence pulse");
    end
    $display("error test done");
  endtask : t_errors

  task automatic t_ext_reset;
    @(posedge clock) sleep_pin <= 1'b0;
    @(posedge clock) err <= 3'h2;
    @(posedge clock) err <= 3'h0;
    step(8);
    @(posedge clock) sleep_pin <= 1'b1;
    fork
      u_model.pull_reset(12);
      begin
        step(10);
        check(in_reset, 1'b1, "external reset ignored");
      end
    join
    step(40);
    check(awake, 1'b1, "asleep after reset");
    check(error_flag_out_b, 1'b1, "error kept over reset");
    $display("external reset test done");
  endtask : t_ext_reset

  task automatic t_power_fail;
    int n;
    n = 0;
    @(posedge clock) power_fail <= 1'b1;
    step(6);
    check(reset_pin_oe, 1'b1, "power fail not driven");
    check(reset_pin_in, 1'b0, "reset wire not low");
    check(in_reset, 1'b1, "power fail not a reset");
    @(posedge clock) power_fail <= 1'b0;
    while (n < 60 && reset_pin_oe === 1'b1)
    begin
      step(1);
      n++;
    end
    check(n >= POR && n < 60, 1'b1, "reset state length");
    step(40);
    $display("power fail test done");
  endtask : t_power_fail

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    step(1);
    t_powerup();
    t_sleep_wake();
    t_errors();
    t_ext_reset();
    t_power_fail();
    report_and_stop();
  end

  // whole run needs about 720 cycles
  initial
  begin
    repeat (6000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb
